// File: bench/tla_adapt_chk.sv
// Checker for tla_adapt: slot timing, sink timing, defects, output buffer.
// Assumes SLOTS above 1 and a line partner that keeps a steady round.
`timescale 1ns/1ps
module tla_adapt_chk #(
    parameter int SLOT_ID = 0 // Slot owned by the block
) (
    input wire logic clk, // Clock
    input wire logic rst, // Sync reset
    input wire logic adaptationSelect, // Activation
    input wire logic txSlotStart, // Tx round start
    input wire tla_pkg::tla_line_s txLine, // Outgoing byte
    input wire logic txDrive, // Slot enable
    input wire logic rxSlotStart, // Rx round start
    input wire logic rxValid, // Rx byte present
    input wire logic recClkEn, // Recovered timing
    input wire logic [7:0] cliOutData, // Client byte out
    input wire logic cliOutValid, // Client byte offered
    input wire logic cliOutReady, // Client takes it
    input wire tla_pkg::tla_status_s status, // Defects
    input wire logic rxOverrun // Dropped byte
);
    import tla_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Slot 0 owner drives a cycle after round start
    property p_txSlot;
        txSlotStart && adaptationSelect && SLOT_ID == 0 |=> txDrive;
    endproperty
    a_txSlot: assert property (p_txSlot) else $error("slot not driven");
    // A deselected instance keeps off the shared slot
    property p_desel;
        !adaptationSelect |=> !txDrive;
    endproperty
    a_desel: assert property (p_desel) else $error("drive while deselected");
    // One byte per owned slot, never two in a row
    property p_oneSlot;
        txDrive |=> !txDrive;
    endproperty
    a_oneSlot: assert property (p_oneSlot) else $error("slot overrun");
    // Frame start carries the clear alignment word
    property p_fs;
        txDrive && txLine.frameStart |-> txLine.data == 8'hf6;
    endproperty
    a_fs: assert property (p_fs) else $error("bad alignment word");
    // Our rx byte gives a timing pulse
    property p_rec;
        rxSlotStart && rxValid && SLOT_ID == 0 |=> recClkEn;
    endproperty
    a_rec: assert property (p_rec) else $error("missing timing pulse");
    // No pulse without an incoming byte
    property p_recIdle;
        !rxValid |=> !recClkEn;
    endproperty
    a_recIdle: assert property (p_recIdle) else $error("spurious timing pulse");
    // All-ones only with a loss defect
    property p_ones;
        status.allOnes |-> status.lossOfFrame || status.pointerLoss;
    endproperty
    a_ones: assert property (p_ones) else $error("all-ones without loss");
    // Label check is muted while the all-ones alarm is raised
    property p_lbl;
        status.allOnes |-> !status.labelMismatch;
    endproperty
    a_lbl: assert property (p_lbl) else $error("label flag during loss");
    // Stalled client sees the same byte held
    property p_hold;
        cliOutValid && !cliOutReady |=> cliOutValid && $stable(cliOutData);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled byte lost");
    // Drops and loss onsets need a byte
    property p_ovr;
        rxOverrun |-> $past(rxValid);
    endproperty
    a_ovr: assert property (p_ovr) else $error("drop without byte");
    property p_lof;
        $rose(status.lossOfFrame) |-> $past(rxValid);
    endproperty
    a_lof: assert property (p_lof) else $error("loss without byte");
endmodule : tla_adapt_chk

bind tla_adapt tla_adapt_chk #(.SLOT_ID(SLOT_ID)) chk (.*);

// File: bench/tla_adapt_tb.sv
// Bench: line loopback via partner, client fed and drained.
// Assumes the block owns slot 0 of four and is not the only instance.
`timescale 1ns/1ps
module tla_adapt_tb;
    import tla_pkg::*;
    localparam int FRAME = 64; // Cycles per frame with four slots
    logic clk = 1'b0, rst = 1'b1, adaptationSelect = 1'b1, alignByPointer = 1'b0;
    logic [7:0] txLabel = 8'h5a, expectedLabel = 8'h5a, cliInData = 8'h01, cliOutData;
    logic cliInValid = 1'b0, cliInReady, txSlotStart, txDrive, rxSlotStart, rxValid;
    logic recClkEn, cliOutValid, cliOutReady = 1'b1, rxOverrun, forceOnes = 1'b0;
    tla_line_s txLine, rxLine; // Line bytes
    tla_status_s status; // Defect levels
    logic feed = 1'b0, cmpOn = 1'b0, ovrSeen = 1'b0; // Bench controls
    logic [7:0] sent[$]; // Bytes accepted, not yet delivered
    int checks = 0, nFail = 0, cycles = 0, taken = 0, t0, nz;
    always #5 clk = ~clk;
    tla_adapt DUT (.*);
    tla_line_model #(.SLOTS(4)) partner (.*);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            nFail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Bounded wait on a status bit
    task automatic wait_bit(input string what, input int idx, input logic val, input int lim);
        for (int i = 0; i < lim && status[idx] !== val; i++) @(negedge clk);
        check(what, 32'(status[idx]), 32'(val));
    endtask : wait_bit
    task automatic reset_check();
        rst = 1'b1;
        repeat (3) @(negedge clk);
        check("status", 32'(status), 32'h8);
        check("txDrive", 32'(txDrive), 32'h0);
        check("cliInReady", 32'(cliInReady), 32'h1);
        check("cliOutValid", 32'(cliOutValid), 32'h0);
        rst = 1'b0;
    endtask : reset_check
    // Feeder: nonzero bytes at falling edges
    always @(negedge clk) begin
        cliInValid = feed;
        cliInData = 8'((taken % 255) + 1);
    end
    // Monitor: scoreboard, overrun flag, hang limit
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            nFail++;
            tally_and_finish();
        end
        if (rxOverrun === 1'b1) ovrSeen = 1'b1;
        if (cliInValid && cliInReady === 1'b1) begin
            sent.push_back(cliInData);
            taken++;
        end
        // Zero bytes are stuffing, skipped
        if (cmpOn && cliOutValid === 1'b1 && cliOutReady && cliOutData !== 8'h00) begin
            if (sent.size() > 0) check("cliOutData", cliOutData, sent.pop_front());
            else check("cliOutExtra", 32'h1, 32'h0);
        end
    end
    initial begin
        reset_check();
        wait_bit("lossOfFrame", 3, 1'b0, 8 * FRAME);
        check("labelMismatch", 32'(status.labelMismatch), 32'h0);
        nz = 0;
        repeat (FRAME) begin
            @(negedge clk);
            if (txDrive && !txLine.frameStart && txLine.data != 8'h00) nz++;
        end
        check("scrambledBytes", 32'(nz > 0), 32'h1);
        expectedLabel = 8'ha5;
        wait_bit("labelMismatch", 0, 1'b1, 3 * FRAME);
        expectedLabel = 8'h5a;
        wait_bit("labelMismatch", 0, 1'b0, 3 * FRAME);
        // Full store: extra byte each frame
        cmpOn = 1'b1;
        feed = 1'b1;
        repeat (2 * FRAME) @(negedge clk);
        t0 = taken;
        repeat (4 * FRAME) @(negedge clk);
        check("bytesPerFourFrames", 32'((taken - t0) inside {[51:53]}), 32'h1);
        feed = 1'b0;
        repeat (4 * FRAME) @(negedge clk);
        check("pending", 32'(sent.size()), 32'h0);
        // Client stall: hold, then drop
        cmpOn = 1'b0;
        cliOutReady = 1'b0;
        feed = 1'b1;
        repeat (2 * FRAME) @(negedge clk);
        check("rxOverrun", 32'(ovrSeen), 32'h1);
        check("cliOutValidStalled", 32'(cliOutValid), 32'h1);
        cliOutReady = 1'b1;
        feed = 1'b0;
        // Deselected: our slot stays silent
        adaptationSelect = 1'b0;
        nz = 0;
        repeat (FRAME) begin
            @(negedge clk);
            if (txDrive !== 1'b0) nz++;
        end
        check("drivesWhileOff", 32'(nz), 32'h0);
        adaptationSelect = 1'b1;
        // All-ones: frame loss, alarm, pointer loss
        forceOnes = 1'b1;
        wait_bit("lossOfFrame", 3, 1'b1, 8 * FRAME);
        wait_bit("allOnes", 1, 1'b1, 4 * FRAME);
        alignByPointer = 1'b1;
        wait_bit("pointerLoss", 2, 1'b1, 4 * FRAME);
        forceOnes = 1'b0;
        alignByPointer = 1'b0;
        wait_bit("lossOfFrame", 3, 1'b0, 8 * FRAME);
        wait_bit("allOnes", 1, 1'b0, 2 * FRAME);
        reset_check();
        tally_and_finish();
    end
endmodule : tla_adapt_tb

// File: bench/tla_line_model.sv
// Line side partner: round timing and a loopback of our slot into the sink.
// Assumes the block owns slot 0 and shares the clock with this model.
`timescale 1ns/1ps
module tla_line_model #(
    parameter int SLOTS = 4 // Slots per round
) (
    input wire logic clk, // Clock
    input wire logic rst, // Sync reset
    input wire logic forceOnes, // Send all-ones in our slot
    input wire tla_pkg::tla_line_s txLine, // Byte from the block
    input wire logic txDrive, // Block drives its slot
    output logic txSlotStart, // Outgoing round start
    output logic rxSlotStart, // Incoming round start
    output tla_pkg::tla_line_s rxLine, // Byte to the block
    output logic rxValid // Byte present
);
    import tla_pkg::*;
    logic [7:0] slotCnt; // Round position
    logic [7:0] lastData; // Last value on the line
    // Rx round lags tx by the output register
    always_ff @(posedge clk) begin
        if (rst) begin
            slotCnt <= 8'h00;
            rxSlotStart <= 1'b0;
            lastData <= 8'h00;
        end else begin
            slotCnt <= (slotCnt == 8'(SLOTS - 1)) ? 8'h00 : slotCnt + 8'h01;
            rxSlotStart <= txSlotStart;
            lastData <= rxLine.data;
        end
    end
    assign txSlotStart = !rst && slotCnt == 8'h00;
    // Idle line toggles so a stale byte never looks valid
    always_comb begin
        rxValid = rxSlotStart && (txDrive || forceOnes);
        rxLine = '{data: ~lastData, frameStart: 1'b0};
        if (forceOnes && rxSlotStart) begin
            rxLine = '{data: 8'hff, frameStart: 1'b1};
        end else if (rxValid) begin
            rxLine = txLine;
        end
    end
endmodule : tla_line_model

// File: core/tla_adapt.sv
// Transport layer adaptation: source mapping with justification and
// scrambling, sink alignment, defect detection, descrambling and smoothing.
// Assumes line and client sides share clk.
`timescale 1ns/1ps
`include "tla_defs.svh"

// Overview of operation
// R01: Source scrambles bytes for transition density
// R02: Sink descrambles back to original bytes
// R03: Sink finds frame start by word/pointer
// R04: Persistent miss declares frame/pointer loss
// R05: All-ones input also raises all-ones alarm
// R06: All defects reported as status outputs
// R07: Source output rate higher, overhead gaps
// R08: Near overflow: extra data in justification
// R09: Near underflow: skip justification opportunity data
// R10: Source writes only its own time slots
// R11: Sink reads only its own time slots
// R12: Only activated instance drives shared slots
// R13: Lone instance is permanently selected
// R14: Sink recovers byte timing from stream
// R15: Sink smooths gapped output to client
// R16: Source inserts payload type label
// R17: Sink compares received label with expected
// R18: Label disagreement raises mismatch status
// R19: Fixed thresholds checked per justification opportunity; the code checks them once per frame, at the alignment word
module tla_adapt #(
    parameter int SLOTS = 4, // Time slots per round on the access point
    parameter int SLOT_ID = 0, // Slot owned by this instance
    parameter int ES_DEPTH = 8, // Elastic store depth in bytes
    parameter bit SINGLE_INSTANCE = 1'b0 // Only instance on the access point
) (
    input wire logic clk, // 100 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic adaptationSelect, // Management activation
    input wire logic alignByPointer, // 1: pointer mode, 0: word search
    input wire logic [7:0] txLabel, // Label code to send
    input wire logic [7:0] expectedLabel, // Label code to expect
    input wire logic [7:0] cliInData, // Client byte in
    input wire logic cliInValid, // Client byte offered
    output logic cliInReady, // Elastic store can take a byte
    input wire logic txSlotStart, // Marks slot 0 of the outgoing round
    output tla_pkg::tla_line_s txLine, // Outgoing byte
    output logic txDrive, // Output enable of our slot
    input wire logic rxSlotStart, // Marks slot 0 of the incoming round
    input wire tla_pkg::tla_line_s rxLine, // Incoming byte, frameStart = mark
    input wire logic rxValid, // Incoming byte present
    output logic recClkEn, // Recovered byte timing pulse
    output logic [7:0] cliOutData, // Client byte out
    output logic cliOutValid, // Client byte offered
    input wire logic cliOutReady, // Client takes the byte
    output tla_pkg::tla_status_s status, // Defects to fault management
    output logic rxOverrun // Pulse: byte dropped, buffer full
);
    import tla_pkg::*;

    localparam int ESW = $clog2(ES_DEPTH);
    localparam int SW = $clog2(SLOTS);

    // Keystream byte and advanced state of the x^7+x^6+1 frame scrambler
    function automatic logic [14:0] tla_scr(input logic [6:0] s);
        logic [6:0] st;
        logic [7:0] key;
        st = s;
        key = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            key[i] = st[6];
            st = {st[5:0], st[6] ^ st[5]};
        end
        return {key, st};
    endfunction : tla_scr

    // Whether this cycle is our slot, given the start mark and the running count
    function automatic logic tla_ours(input logic start, input logic [SW-1:0] cnt);
        return start ? (SLOT_ID == 0) : (cnt == SW'(SLOT_ID));
    endfunction : tla_ours

    // ---------------- Source side state ----------------
    logic [7:0] esMem [ES_DEPTH]; // Elastic store
    logic [ESW-1:0] esWr, esRd, next_esWr, next_esRd; // Store pointers
    logic [ESW:0] esCnt, next_esCnt; // Store fill level
    logic [SW-1:0] txSlot, next_txSlot; // Slot counter of outgoing round
    logic [3:0] txPos, next_txPos; // Byte position in outgoing frame
    logic [6:0] txScr, next_txScr; // Scrambler state
    logic [7:0] txJc, next_txJc; // Justification decision of this frame
    tla_line_s next_txLine; // Next outgoing byte
    logic next_txDrive; // Next output enable
    logic txActive; // Instance may drive its slots
    logic txOurs; // This cycle is our slot
    logic push, pop; // Store write and read
    logic [14:0] txKey; // Keystream for this byte

    assign txActive = SINGLE_INSTANCE | adaptationSelect; // R12 R13
    assign cliInReady = (esCnt != (ESW+1)'(ES_DEPTH));
    assign push = cliInValid & cliInReady;
    assign txOurs = tla_ours(txSlotStart, txSlot); // R10
    assign txKey = tla_scr(txScr);

    // Frame builder: overhead bytes make the gaps, payload drains the store
    always_comb begin
        next_txSlot = txSlotStart ? SW'(1) : ((txSlot == SW'(SLOTS - 1)) ? '0 : txSlot + 1'b1);
        next_txPos = txPos;
        next_txScr = txScr;
        next_txJc = txJc;
        next_txLine = txLine;
        next_txDrive = 1'b0;
        pop = 1'b0;
        if (txOurs) begin // R10
            next_txPos = (txPos == 4'(`TLA_FRAME_LEN - 1)) ? '0 : txPos + 1'b1;
            next_txScr = txKey[6:0];
            next_txLine.frameStart = (txPos == `TLA_POS_ALIGN);
            case (txPos)
                `TLA_POS_ALIGN: begin
                    // Decide once per frame, before the opportunities pass
                    if (esCnt >= 5'(`TLA_ES_HIGH)) begin // R19
                        next_txJc = `TLA_JC_INC; // R08
                    end else if (esCnt <= 5'(`TLA_ES_LOW)) begin // R19
                        next_txJc = `TLA_JC_DEC; // R09
                    end else begin
                        next_txJc = `TLA_JC_NORM;
                    end
                    next_txScr = `TLA_SCR_SEED;
                    next_txLine.data = `TLA_ALIGN_WORD; // Sent in clear for the search
                end
                `TLA_POS_LABEL: next_txLine.data = txLabel ^ txKey[14:7]; // R16 R01
                `TLA_POS_JCTRL: next_txLine.data = txJc ^ txKey[14:7]; // R01
                `TLA_POS_NJO: begin
                    pop = (txJc == `TLA_JC_INC) && (esCnt != '0); // R08
                    next_txLine.data = (pop ? esMem[esRd] : `TLA_STUFF_BYTE) ^ txKey[14:7];
                end
                `TLA_POS_PJO: begin
                    pop = (txJc != `TLA_JC_DEC) && (esCnt != '0); // R09
                    next_txLine.data = (pop ? esMem[esRd] : `TLA_STUFF_BYTE) ^ txKey[14:7];
                end
                default: begin
                    // Empty store sends stuffing; justification keeps this rare
                    pop = (esCnt != '0); // R07
                    next_txLine.data = (pop ? esMem[esRd] : `TLA_STUFF_BYTE) ^ txKey[14:7];
                end
            endcase
            next_txDrive = txActive; // R12
            pop = pop & txActive;
        end
        next_esWr = push ? esWr + 1'b1 : esWr;
        next_esRd = pop ? esRd + 1'b1 : esRd;
        next_esCnt = esCnt + (ESW+1)'(push) - (ESW+1)'(pop);
    end

    // Source registers; store pointers wrap for power-of-two depth
    always_ff @(posedge clk) begin
        if (rst) begin
            esWr <= '0;
            esRd <= '0;
            esCnt <= '0;
            txSlot <= '0;
            txPos <= '0;
            txScr <= `TLA_SCR_SEED;
            txJc <= `TLA_JC_NORM;
            txLine <= '0;
            txDrive <= 1'b0;
        end else begin
            esWr <= next_esWr;
            esRd <= next_esRd;
            esCnt <= next_esCnt;
            txSlot <= next_txSlot;
            txPos <= next_txPos;
            txScr <= next_txScr;
            txJc <= next_txJc;
            txLine <= next_txLine;
            txDrive <= next_txDrive;
        end
    end

    // Store array carries no reset; only written bytes are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            esMem[esWr] <= cliInData;
        end
    end

    // ---------------- Sink side state ----------------
    tla_sync_e rxState, next_rxState; // Alignment state
    logic [SW-1:0] rxSlot, next_rxSlot; // Slot counter of incoming round
    logic [3:0] rxPos, next_rxPos; // Byte position in incoming frame
    logic [6:0] rxScr, next_rxScr; // Descrambler state
    logic [7:0] rxJc, next_rxJc; // Received justification control
    logic [2:0] hitCnt, next_hitCnt; // Consecutive good alignment words
    logic [2:0] missCnt, next_missCnt; // Consecutive missing words or pointers
    logic [4:0] onesRun, next_onesRun; // Consecutive all-ones bytes
    tla_status_s next_status; // Next defect report
    logic next_recClkEn; // Next timing pulse
    logic rxOurs, rxTake; // Our slot, and a byte in it
    logic [14:0] rxKey; // Keystream for this byte
    logic [7:0] plain; // Descrambled byte
    logic locked; // Frame position trusted
    logic capture; // Byte is client payload

    assign rxOurs = tla_ours(rxSlotStart, rxSlot); // R11
    assign rxTake = rxOurs & rxValid; // R11
    assign rxKey = tla_scr(rxScr);
    assign plain = rxLine.data ^ rxKey[14:7]; // R02
    assign locked = alignByPointer ? !status.pointerLoss : (rxState == TLA_SYNC);

    // Alignment, defect detection, label check and payload selection
    always_comb begin
        next_rxSlot = rxSlotStart ? SW'(1) : ((rxSlot == SW'(SLOTS - 1)) ? '0 : rxSlot + 1'b1);
        next_rxState = rxState;
        next_rxPos = rxPos;
        next_rxScr = rxScr;
        next_rxJc = rxJc;
        next_hitCnt = hitCnt;
        next_missCnt = missCnt;
        next_onesRun = onesRun;
        next_status = status;
        next_recClkEn = rxTake; // R14
        capture = 1'b0;
        if (rxTake) begin
            next_onesRun = (rxLine.data != `TLA_ONES_BYTE) ? '0 :
                ((onesRun == 5'(`TLA_FRAME_LEN)) ? onesRun : onesRun + 1'b1);
            next_rxPos = (rxPos == 4'(`TLA_FRAME_LEN - 1)) ? '0 : rxPos + 1'b1;
            next_rxScr = rxKey[6:0];
            if (alignByPointer) begin
                // Pointer mode: frame start is supplied, pointer sits at position 0
                next_rxState = TLA_HUNT;
                next_status.lossOfFrame = 1'b0;
                if (rxLine.frameStart) begin // R03
                    next_rxPos = 4'h1;
                    next_rxScr = `TLA_SCR_SEED;
                    if (rxLine.data > 8'(`TLA_POS_PJO) && rxLine.data < 8'(`TLA_FRAME_LEN)) begin
                        next_missCnt = '0;
                        next_status.pointerLoss = 1'b0;
                    end else if (missCnt + 1'b1 >= `TLA_LOP_LIMIT) begin
                        next_status.pointerLoss = 1'b1; // R04
                    end else begin
                        next_missCnt = missCnt + 1'b1;
                    end
                end
            end else begin
                next_status.pointerLoss = 1'b0;
                case (rxState)
                    TLA_HUNT: begin
                        // Search every byte of our slots for the word
                        if (rxLine.data == `TLA_ALIGN_WORD) begin // R03
                            next_rxState = TLA_PRESYNC;
                            next_rxPos = 4'h1;
                            next_rxScr = `TLA_SCR_SEED;
                            next_hitCnt = 3'h1;
                            next_missCnt = '0;
                        end
                    end
                    TLA_PRESYNC, TLA_SYNC: begin
                        if (rxPos == `TLA_POS_ALIGN) begin
                            next_rxScr = `TLA_SCR_SEED;
                            if (rxLine.data == `TLA_ALIGN_WORD) begin
                                next_missCnt = '0;
                                if (rxState == TLA_PRESYNC) begin
                                    next_hitCnt = hitCnt + 1'b1;
                                end
                                if (rxState == TLA_PRESYNC && hitCnt + 1'b1 >= `TLA_HIT_LIMIT) begin
                                    next_rxState = TLA_SYNC;
                                    next_status.lossOfFrame = 1'b0;
                                end
                            end else if (rxState == TLA_PRESYNC) begin
                                next_rxState = TLA_HUNT;
                            end else if (missCnt + 1'b1 >= `TLA_MISS_LIMIT) begin
                                next_rxState = TLA_HUNT; // R04
                                next_status.lossOfFrame = 1'b1; // R04
                                next_missCnt = '0;
                            end else begin
                                next_missCnt = missCnt + 1'b1;
                            end
                        end
                    end
                    default: next_rxState = TLA_HUNT;
                endcase
            end
            if (locked) begin
                case (rxPos)
                    `TLA_POS_ALIGN: capture = 1'b0;
                    `TLA_POS_LABEL: next_status.labelMismatch = (plain != expectedLabel); // R17 R18
                    `TLA_POS_JCTRL: next_rxJc = plain;
                    `TLA_POS_NJO: capture = (rxJc == `TLA_JC_INC); // R08
                    `TLA_POS_PJO: capture = (rxJc != `TLA_JC_DEC); // R09
                    default: capture = 1'b1;
                endcase
            end else begin
                // Label is meaningless without alignment; the loss defect covers it
                next_status.labelMismatch = 1'b0;
            end
        end
        // All-ones counts only as an explanation of an alignment defect
        next_status.allOnes = (next_status.lossOfFrame | next_status.pointerLoss)
            & (next_onesRun == 5'(`TLA_FRAME_LEN)); // R05 R06
        if (next_status.lossOfFrame | next_status.pointerLoss) next_status.labelMismatch = 1'b0; // R18
    end

    // Sink registers; loss of frame starts raised until word alignment is proven or a byte is taken in pointer mode
    always_ff @(posedge clk) begin
        if (rst) begin
            rxState <= TLA_HUNT;
            rxSlot <= '0;
            rxPos <= '0;
            rxScr <= `TLA_SCR_SEED;
            rxJc <= `TLA_JC_NORM;
            hitCnt <= '0;
            missCnt <= '0;
            onesRun <= '0;
            status <= 4'b1000;
            recClkEn <= 1'b0;
        end else begin
            rxState <= next_rxState;
            rxSlot <= next_rxSlot;
            rxPos <= next_rxPos;
            rxScr <= next_rxScr;
            rxJc <= next_rxJc;
            hitCnt <= next_hitCnt;
            missCnt <= next_missCnt;
            onesRun <= next_onesRun;
            status <= next_status; // R06
            recClkEn <= next_recClkEn; // R14
        end
    end

    // ---------------- Two-entry buffer with smoothing ----------------
    logic [7:0] bufMem [2]; // Buffer entries
    logic bufWr, bufRd, next_bufWr, next_bufRd; // Buffer pointers
    logic [1:0] bufCnt, next_bufCnt; // Buffer fill
    logic [7:0] pace, next_pace; // Rate accumulator
    logic credit, next_credit; // One release earned
    logic bufPush, bufPop; // Buffer write and read
    logic next_rxOverrun; // Next drop pulse

    assign bufPush = capture & (bufCnt != 2'h2);
    assign cliOutValid = (bufCnt != '0) & (credit | bufCnt == 2'h2); // R15
    assign bufPop = cliOutValid & cliOutReady;
    assign cliOutData = bufMem[bufRd];

    // Releases are paced at the mean payload rate; a full buffer releases early
    // since two entries cannot absorb a long burst, a deliberate trade-off
    always_comb begin
        next_bufWr = bufPush ? ~bufWr : bufWr;
        next_bufRd = bufPop ? ~bufRd : bufRd;
        next_bufCnt = bufCnt + 2'(bufPush) - 2'(bufPop);
        next_pace = pace;
        next_credit = credit & ~bufPop;
        next_rxOverrun = capture & (bufCnt == 2'h2);
        if (rxOurs) begin // R15
            if (pace + 8'(`TLA_PAYLOAD_PER_FRAME) >= 8'(`TLA_FRAME_LEN)) begin
                next_pace = pace + 8'(`TLA_PAYLOAD_PER_FRAME) - 8'(`TLA_FRAME_LEN);
                next_credit = 1'b1;
            end else begin
                next_pace = pace + 8'(`TLA_PAYLOAD_PER_FRAME);
            end
        end
    end

    // Buffer control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            bufWr <= 1'b0;
            bufRd <= 1'b0;
            bufCnt <= '0;
            pace <= '0;
            credit <= 1'b0;
            rxOverrun <= 1'b0;
        end else begin
            bufWr <= next_bufWr;
            bufRd <= next_bufRd;
            bufCnt <= next_bufCnt;
            pace <= next_pace;
            credit <= next_credit;
            rxOverrun <= next_rxOverrun;
        end
    end

    // Buffer data, cleared at reset so the data output is defined
    always_ff @(posedge clk) begin
        if (rst) begin
            bufMem[0] <= '0;
            bufMem[1] <= '0;
        end else if (bufPush) begin
            bufMem[bufWr] <= plain;
        end
    end
endmodule : tla_adapt

// File: core/tla_defs.svh
// Constants of the transport layer adaptation block: frame layout, codes,
// thresholds. Included by the adaptation module.
`ifndef TLA_DEFS_SVH
`define TLA_DEFS_SVH
`define TLA_FRAME_LEN 16
`define TLA_POS_ALIGN 4'h0
`define TLA_POS_LABEL 4'h1
`define TLA_POS_JCTRL 4'h2
`define TLA_POS_NJO 4'h3
`define TLA_POS_PJO 4'h4
`define TLA_PAYLOAD_PER_FRAME 5'h0c
`define TLA_ALIGN_WORD 8'hf6
`define TLA_JC_NORM 8'h00
`define TLA_JC_INC 8'h0f
`define TLA_JC_DEC 8'hf0
`define TLA_STUFF_BYTE 8'h00
`define TLA_ONES_BYTE 8'hff
`define TLA_SCR_SEED 7'h7f
`define TLA_ES_HIGH 4'h6
`define TLA_ES_LOW 4'h2
`define TLA_HIT_LIMIT 3'h2
`define TLA_MISS_LIMIT 3'h4
`define TLA_LOP_LIMIT 3'h3
`endif

// File: core/tla_pkg.sv
// Types shared by the transport layer adaptation block.
// Assumes tla_defs.svh is on the include path.
package tla_pkg;
    // Frame alignment progress, Gray coded along hunt -> presync -> sync
    typedef enum logic [1:0] {
        TLA_HUNT = 2'b00,
        TLA_PRESYNC = 2'b01,
        TLA_SYNC = 2'b11
    } tla_sync_e;
    // One byte position on the combined time-division signal
    typedef struct packed {
        logic [7:0] data; // Byte value
        logic frameStart; // Byte is the first of a frame
    } tla_line_s;
    // Defect report towards fault management
    typedef struct packed {
        logic lossOfFrame; // loss_of_frame_defect
        logic pointerLoss; // pointer_loss_defect
        logic allOnes; // all_ones_alarm_defect
        logic labelMismatch; // payload_type_label mismatch
    } tla_status_s;
endpackage : tla_pkg
